// [hdl/fmn_consts.svh]
`ifndef FMN_CONSTS_SVH
`define FMN_CONSTS_SVH
// Audio sample width and I2S slot width
`define FMN_SAMPLE_W 16
`define FMN_SLOT_W 32
// Phase accumulator width
`define FMN_PHASE_W 24
// DAC word width, LSB at bit 0
`define FMN_DAC_W 4
// Shift that scales a signed sample into a phase step deviation
`define FMN_DEV_SHIFT 0
`endif

// [hdl/fmn_pkg.sv]
`include "fmn_consts.svh"
package fmn_pkg;
  typedef logic [`FMN_PHASE_W-1:0]  fmn_phase_t;
  typedef logic [`FMN_SAMPLE_W-1:0] fmn_sample_t;
  typedef logic [`FMN_DAC_W-1:0]    fmn_dac_t;
  typedef enum logic {FMN_LEFT, FMN_RIGHT} fmn_chan_t;
endpackage

// [hdl/fmn_sample_if.sv]
`timescale 1ns/1ns
interface fmn_sample_if;
  import fmn_pkg::*;
  fmn_sample_t sample;
  logic        valid;
  modport src (output sample, output valid);
  modport dst (input sample, input valid);
endinterface

// [hdl/fmn_i2s_rx.sv]
`timescale 1ns/1ns
`include "fmn_consts.svh"
module fmn_i2s_rx
  import fmn_pkg::*;
(
  input  wire logic  mclk,     // System clock
  input  wire logic  srst,     // Sync reset
  input  wire logic  ce,       // Clock enable
  input  wire logic  bclk_s,   // Synchronised bit clock
  input  wire logic  din_s,    // Synchronised serial data
  input  wire logic  ws_s,     // Synchronised word select
  fmn_sample_if.src  smp       // Completed left sample
);
  logic                   bclk_d;
  logic                   ws_d;
  logic [`FMN_SLOT_W-1:0] shreg;
  logic [5:0]             bitcnt;
  fmn_sample_t            sample;
  logic                   valid;
  logic                   next_bclk_d;
  logic                   next_ws_d;
  logic [`FMN_SLOT_W-1:0] next_shreg;
  logic [5:0]             next_bitcnt;
  fmn_sample_t            next_sample;
  logic                   next_valid;
  logic                   rise;

  assign rise = bclk_s & ~bclk_d;

  always_comb
  begin
    next_bclk_d = bclk_s;
    next_ws_d   = ws_d;
    next_shreg  = shreg;
    next_bitcnt = bitcnt;
    next_sample = sample;
    next_valid  = 1'b0;
    if (rise)
    begin
      next_ws_d = ws_s;
      // The LSB shares its bclk rise with the WS edge, so shift before closing the word
      if (bitcnt < 6'(`FMN_SAMPLE_W))
      begin
        next_shreg  = {shreg[`FMN_SLOT_W-2:0], din_s};
        next_bitcnt = bitcnt + 6'h01;
      end
      // WS changes one bit before the MSB, so a WS edge closes the previous word
      if (ws_s != ws_d)
      begin
        next_bitcnt = 6'h00;
        if (ws_d == 1'b0 && bitcnt >= 6'(`FMN_SAMPLE_W-1))
        begin
          next_sample = next_shreg[`FMN_SAMPLE_W-1:0];
          next_valid  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bclk_d <= 1'b0;
      // Matches the idle (right) level so the first left edge is seen
      ws_d   <= 1'b1;
      shreg  <= '0;
      bitcnt <= 6'h00;
      sample <= '0;
      valid  <= 1'b0;
    end
    else if (ce)
    begin
      bclk_d <= next_bclk_d;
      ws_d   <= next_ws_d;
      shreg  <= next_shreg;
      bitcnt <= next_bitcnt;
      sample <= next_sample;
      valid  <= next_valid;
    end
  end

  assign smp.sample = sample;
  assign smp.valid  = valid;

  a_word_complete: assert property (@(posedge mclk) disable iff (srst)
    valid && $past(ce) |-> $past(bitcnt) >= 6'(`FMN_SAMPLE_W-1))
    else $error("sample updated before a full word");
  a_sample_hold: assert property (@(posedge mclk) disable iff (srst)
    !valid && $past(ce) |-> $stable(sample))
    else $error("sample changed without a completed word");
endmodule

// [hdl/fmn_top.sv]
`timescale 1ns/1ns
`include "fmn_consts.svh"
// How it works
// - Phase step is carrier word plus sample
// - Step deviation tracks sample level
// - Sine approximation by shifts and adds only
// - Source sends I2S; device deserialises samples
// - Output is 4-bit unsigned, bit 0 LSB
module fmn_top
  import fmn_pkg::*;
(
  input  wire logic       mclk,      // 250 MHz system clock
  input  wire logic       srst,      // Sync reset, active high
  input  wire logic       ce,        // Clock enable, freezes state when low
  input  wire logic       i2s_bclk,  // I2S bit clock pin
  input  wire logic       i2s_data,  // I2S serial data pin
  input  wire logic       i2s_wsel,  // I2S word select pin
  input  wire fmn_phase_t carrier,   // Carrier frequency control word
  output logic            sample_ok, // Pulse: new sample taken
  output fmn_dac_t        dac        // DAC word, bit 0 LSB
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] bclk_sy;
  logic [1:0] data_sy;
  logic [1:0] ws_sy;
  fmn_sample_if smp ();

  // Pins come from another clock; second stage only is read
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      bclk_sy <= 2'h0;
      data_sy <= 2'h0;
      ws_sy   <= 2'h0;
    end
    else if (ce)
    begin
      bclk_sy <= {bclk_sy[0], i2s_bclk};
      data_sy <= {data_sy[0], i2s_data};
      ws_sy   <= {ws_sy[0], i2s_wsel};
    end
  end

  fmn_i2s_rx u_rx (
    .mclk   (mclk),
    .srst   (srst),
    .ce     (ce),
    .bclk_s (bclk_sy[1]),
    .din_s  (data_sy[1]),
    .ws_s   (ws_sy[1]),
    .smp    (smp.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  fmn_sample_t audio;
  fmn_phase_t  phase;
  fmn_dac_t    dac_q;
  fmn_sample_t next_audio;
  fmn_phase_t  next_phase;
  fmn_dac_t    next_dac;
  fmn_phase_t  step;

  // Sign-extend the sample so deviation is symmetric around the carrier
  function automatic fmn_phase_t dev(input fmn_sample_t s);
    dev = fmn_phase_t'({{(`FMN_PHASE_W-`FMN_SAMPLE_W){s[`FMN_SAMPLE_W-1]}}, s}) <<< `FMN_DEV_SHIFT;
  endfunction

  // Triangle folded then bent by two shift-add segments; far cheaper than a table
  function automatic fmn_dac_t sine4(input fmn_phase_t p);
    logic [6:0] t;
    logic [6:0] m;
    logic [7:0] a;
    t = p[`FMN_PHASE_W-2] ? ~p[`FMN_PHASE_W-3 -: 7] : p[`FMN_PHASE_W-3 -: 7];
    m = t[6] ? 7'(t + (~t >> 2)) : 7'(t + (t >> 2));
    a = p[`FMN_PHASE_W-1] ? 8'(8'h80 - {1'b0, m}) : 8'(8'h80 + {1'b0, m});
    if (a[7] && !p[`FMN_PHASE_W-1] && m[6] && m[5] && m[4] && m[3])
      a = 8'hFF;
    sine4 = a[7:4];
  endfunction

  assign step = fmn_phase_t'(carrier + dev(audio));

  always_comb
  begin
    next_audio = smp.valid ? smp.sample : audio;
    next_phase = fmn_phase_t'(phase + step);
    next_dac   = sine4(phase);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      audio <= '0;
      phase <= '0;
      dac_q <= '0;
    end
    else if (ce)
    begin
      audio <= next_audio;
      phase <= next_phase;
      dac_q <= next_dac;
    end
  end

  assign dac       = dac_q;
  assign sample_ok = smp.valid;

  ////////////////////////////////////////////////////////////////////////////
  a_phase_step: assert property (@(posedge mclk) disable iff (srst)
    ce |=> phase == fmn_phase_t'($past(phase) + $past(carrier) + dev($past(audio))))
    else $error("phase did not advance by carrier plus sample");
  a_deviation: assert property (@(posedge mclk) disable iff (srst)
    fmn_phase_t'(step - carrier) == dev(audio))
    else $error("step deviation not proportional to sample");
  a_audio_take: assert property (@(posedge mclk) disable iff (srst)
    ce && smp.valid |=> audio == $past(smp.sample))
    else $error("completed word not taken");
  a_dac_follow: assert property (@(posedge mclk) disable iff (srst)
    ce |=> dac == sine4($past(phase)))
    else $error("dac not from phase");
  a_dac_peak: assert property (@(posedge mclk) disable iff (srst)
    ce && phase[`FMN_PHASE_W-1:`FMN_PHASE_W-2] == 2'h0 && phase[`FMN_PHASE_W-3 -: 7] == 7'h7F |=> dac == 4'hF)
    else $error("dac peak not full scale");
  a_freeze: assert property (@(posedge mclk) disable iff (srst)
    !ce |=> $stable(phase) && $stable(dac))
    else $error("state moved while clock enable low");
  a_deser_gap: assert property (@(posedge mclk) disable iff (srst)
    smp.valid && ce |=> !smp.valid)
    else $error("back to back sample strobes");
  a_trough: assert property (@(posedge mclk) disable iff (srst)
    ce && phase[`FMN_PHASE_W-1:`FMN_PHASE_W-2] == 2'h2 && phase[`FMN_PHASE_W-3 -: 7] == 7'h7F |=> dac <= 4'h1)
    else $error("dac trough too high");

  c_sample: cover property (@(posedge mclk) disable iff (srst) smp.valid);
  c_neg_audio: cover property (@(posedge mclk) disable iff (srst) audio[`FMN_SAMPLE_W-1]);
  c_dac_max: cover property (@(posedge mclk) disable iff (srst) dac == 4'hF);
  c_wrap: cover property (@(posedge mclk) disable iff (srst) ce && phase[`FMN_PHASE_W-1] ##1 !phase[`FMN_PHASE_W-1]);
endmodule

// [bench/fmn_i2s_src.sv]
`timescale 1ns/1ns
module fmn_i2s_src (
  output logic bclk,  // Bit clock, idle low between frames
  output logic data,  // Serial data, MSB first
  output logic wsel   // Word select, low = left
);
  initial
  begin
    bclk = 1'b0;
    data = 1'b0;
    wsel = 1'b1;
  end
  // Left slot of nb bits, then a 16-bit right slot; data lags wsel by one bit
  task automatic frame(input logic [15:0] l, input logic [15:0] r, input int nb);
    logic w[$];
    logic d[$];
    for (int i = 0; i < nb + 16; i++)
    begin
      w.push_back(i >= nb);
      d.push_back(i < nb ? (i < 16 ? l[15 - i] : 1'b0) : r[15 + nb - i]);
    end
    for (int k = 0; k <= w.size(); k++)
    begin
      wsel = (k < w.size()) ? w[k] : 1'b1;
      data = (k == 0) ? ~data : d[k - 1];
      #62 bclk = 1'b1;
      #63 bclk = 1'b0;
    end
    // Released line must not keep showing the last bit
    data = ~data;
  endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import fmn_pkg::*;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  fmn_phase_t  carrier = 24'h000000;
  logic        sample_ok;
  fmn_dac_t    dac;
  logic        bclk;
  logic        data;
  logic        wsel;
  int          mismatches = 0;
  int          total_checks = 0;
  int          seed = 67941;
  fmn_phase_t  ph;
  fmn_sample_t au;
  fmn_dac_t    exp_dac;
  fmn_sample_t q[$];
  fmn_sample_t smp;
  always #2 mclk = ~mclk;
  fmn_top u_fmn_top (.mclk(mclk), .srst(srst), .ce(ce), .i2s_bclk(bclk), .i2s_data(data),
    .i2s_wsel(wsel), .carrier(carrier), .sample_ok(sample_ok), .dac(dac));
  fmn_i2s_src u_fmn_i2s_src (.bclk(bclk), .data(data), .wsel(wsel));
  ////////////////////////////////////////////////////////////////////////
  function automatic fmn_dac_t sine4(input fmn_phase_t p);
    logic [6:0] t;
    logic [6:0] nt;
    logic [8:0] a;
    t = p[22] ? ~p[21:15] : p[21:15];
    nt = ~t;
    a = p[23] ? 9'h080 - (t + (t[6] ? nt >> 2 : t >> 2)) : 9'h080 + (t + (t[6] ? nt >> 2 : t >> 2));
    return (a > 9'h0FF) ? 4'hF : a[7:4];
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reference NCO; blocking reads see pre-edge inputs since stimulus is NBA
  always @(posedge mclk)
  begin
    if (srst)
    begin
      ph = 24'h000000;
      au = 16'h0000;
      exp_dac = 4'h0;
      check({23'h0, sample_ok}, 24'h0);
    end
    else if (ce)
    begin
      exp_dac = sine4(ph);
      ph = ph + carrier + {{8{au[15]}}, au};
      if (sample_ok === 1'b1 && q.size() == 0)
        check(24'h1, 24'h0);
      else if (sample_ok === 1'b1)
        au = q.pop_front();
    end
    #1 check({20'h0, dac}, {20'h0, exp_dac});
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic send(input fmn_sample_t l, input int nb);
    @(posedge mclk);
    carrier <= 24'($random(seed));
    if (nb >= 16)
      q.push_back(l);
    u_fmn_i2s_src.frame(l, 16'($random(seed)), nb);
    repeat (20) @(posedge mclk);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    send(16'($random(seed)), 16);
    send(16'($random(seed)), 12);
    send(16'($random(seed)), 20);
    send(16'h8000, 16);
    send(16'h7FFF, 16);
    send(16'h0000, 16);
    // Clock enable gaps must freeze phase and output alike
    repeat (200)
    begin
      @(posedge mclk);
      ce <= 1'($random(seed));
      carrier <= 24'($random(seed));
    end
    @(posedge mclk);
    ce <= 1'b1;
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    send(16'h8001, 16);
    check(q.size(), 24'h0);
    report_and_stop();
  end
endmodule
